// ### hw/icw_watchdog.v
// instruction clock watchdog: down counter, underflow flags, enable flag, reset pin drive
//
// Behaviour
// - after reset, 16-bit counter decrements once per instruction clock from all ones
// - count pulse after reaching all ones again sets first underflow flag
// - underflow with first flag and enable flag set sets second flag and watchdog reset
// - watchdog reset turns on reset pin pull-down, driving pin low
// - watchdog reset only happens while enable flag is one
// - enable flag set on system reset and on back-up entry
// - enable flag cleared only by disable instruction directly followed by service
// - disable instruction alone leaves enable flag and watchdog running
// - service with first flag set clears it and skips, but a same-cycle underflow keeps it set; otherwise no skip
// - service skip works even while watchdog disabled
// - back-up entry reinitialises first flag and counter
// - after back-up return the watchdog is active and counting again
`timescale 1ns/100ps
`default_nettype none
`include "icw_defs.vh"

module icw_watchdog (
	// clock and reset
	input wire clock_i,
	input wire rstn_i,
	// instruction stream from the core, same clock
	input wire instr_clk_i,
	input wire watchdog_service_instr_i,
	input wire watchdog_disable_instr_i,
	input wire instr_exec_i,
	input wire backup_entry_i,
	// answers to the core
	output reg skip_next_o,
	output reg watchdog_enable_flag_o,
	output reg first_underflow_flag_o,
	output reg second_underflow_flag_o,
	output reg watchdog_reset_o,
	// reset pin, open drain: oe low drives
	output reg reset_pin_out_o,
	output reg reset_pin_oe_n_o
);

	reg rst_meta;
	reg rst_sync;
	reg [`ICW_CNT_W-1:0] watchdog_down_counter;
	reg disable_pending;
	reg started;
	wire count_pulse;
	wire underflow;
	wire [`ICW_CNT_W-1:0] next_count;

	// reset release through two flops
	always @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	wire svc_exec;
	wire dis_exec;
	wire pair_done;
	wire counter_at_top;
	wire second_hit;

	// the core hands over one count pulse per machine cycle on this clock
	assign count_pulse = instr_clk_i;
	assign svc_exec = instr_exec_i && watchdog_service_instr_i;
	assign dis_exec = instr_exec_i && watchdog_disable_instr_i;
	// any other executed instruction in between breaks the pair
	assign pair_done = svc_exec && disable_pending;
	// underflow is the pulse after the count has wrapped back to all ones
	assign counter_at_top = (watchdog_down_counter == `ICW_CNT_INIT);
	assign underflow = count_pulse && started && counter_at_top;
	// second underflow with the flag still set; a disabled watchdog never resets
	assign second_hit = underflow && first_underflow_flag_o && watchdog_enable_flag_o;
	assign next_count = watchdog_down_counter - `ICW_CNT_STEP;

	// down counter, restarted from all ones by reset and back-up entry
	// it runs even while disabled, so re-enabling needs no reload
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			watchdog_down_counter <= `ICW_CNT_INIT;
		end
		else if (backup_entry_i)
		begin
			watchdog_down_counter <= `ICW_CNT_INIT;
		end
		else if (count_pulse)
		begin
			watchdog_down_counter <= next_count;
		end
		else
		begin
			watchdog_down_counter <= watchdog_down_counter;
		end
	end

	// started keeps the freshly loaded all ones from counting as an underflow
	// only a wrap after the first pulse may set the first flag
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			started <= 1'b0;
		end
		else if (backup_entry_i)
		begin
			started <= 1'b0;
		end
		else if (count_pulse)
		begin
			started <= 1'b1;
		end
		else
		begin
			started <= started;
		end
	end

	// remembers that the last executed instruction was the disable
	// a lone disable only arms this, it never stops the watchdog
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			disable_pending <= 1'b0;
		end
		else if (backup_entry_i)
		begin
			disable_pending <= 1'b0;
		end
		else if (instr_exec_i)
		begin
			disable_pending <= dis_exec;
		end
		else
		begin
			disable_pending <= disable_pending;
		end
	end

	// enable flag: set by reset and back-up, cleared only by the pair
	// back-up wins so the core always wakes up guarded
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			watchdog_enable_flag_o <= 1'b1;
		end
		else if (backup_entry_i)
		begin
			watchdog_enable_flag_o <= 1'b1;
		end
		else if (pair_done)
		begin
			watchdog_enable_flag_o <= 1'b0;
		end
		else
		begin
			watchdog_enable_flag_o <= watchdog_enable_flag_o;
		end
	end

	// skip request, one cycle, independent of the enable flag
	// the core must take it in the cycle it stands
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			skip_next_o <= 1'b0;
		end
		else if (backup_entry_i)
		begin
			skip_next_o <= 1'b0;
		end
		else
		begin
			skip_next_o <= svc_exec && first_underflow_flag_o;
		end
	end

	// first flag: underflow set wins over a same-cycle service clear
	// losing an underflow would hide a run-away, a spare skip is harmless
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			first_underflow_flag_o <= 1'b0;
		end
		else if (backup_entry_i)
		begin
			first_underflow_flag_o <= 1'b0;
		end
		else if (underflow)
		begin
			first_underflow_flag_o <= 1'b1;
		end
		else if (svc_exec)
		begin
			first_underflow_flag_o <= 1'b0;
		end
		else
		begin
			first_underflow_flag_o <= first_underflow_flag_o;
		end
	end

	// second flag: sticky until a system reset
	// back-up entry leaves it alone
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			second_underflow_flag_o <= 1'b0;
		end
		else if (backup_entry_i)
		begin
			second_underflow_flag_o <= second_underflow_flag_o;
		end
		else if (second_hit)
		begin
			second_underflow_flag_o <= 1'b1;
		end
		else
		begin
			second_underflow_flag_o <= second_underflow_flag_o;
		end
	end

	// watchdog reset request, held until the system reset arrives
	// holding it keeps the pin low long enough for every block to see it
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			watchdog_reset_o <= 1'b0;
		end
		else if (backup_entry_i)
		begin
			watchdog_reset_o <= watchdog_reset_o;
		end
		else if (second_hit)
		begin
			watchdog_reset_o <= 1'b1;
		end
		else
		begin
			watchdog_reset_o <= watchdog_reset_o;
		end
	end

	// reset pin pull-down: oe low turns the transistor on
	// set on the same edge as the request, so pin and flag never disagree
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			reset_pin_oe_n_o <= 1'b1;
		end
		else if (backup_entry_i)
		begin
			reset_pin_oe_n_o <= reset_pin_oe_n_o;
		end
		else if (second_hit)
		begin
			reset_pin_oe_n_o <= 1'b0;
		end
		else
		begin
			reset_pin_oe_n_o <= reset_pin_oe_n_o;
		end
	end

	// the pin is open drain: only ever driven low
	// the external pull-up supplies the high level
	always @(posedge clock_i or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			reset_pin_out_o <= 1'b0;
		end
		else if (backup_entry_i)
		begin
			reset_pin_out_o <= 1'b0;
		end
		else
		begin
			reset_pin_out_o <= 1'b0;
		end
	end

endmodule // icw_watchdog
`default_nettype wire

// ### inc/icw_defs.vh
// constants for the instruction clock watchdog
`ifndef ICW_DEFS_VH
`define ICW_DEFS_VH
`define ICW_CNT_W 16
`define ICW_CNT_INIT 16'hffff
`define ICW_CNT_ZERO 16'h0000
`define ICW_CNT_STEP 16'h0001
`endif

// ### tb/icw_core_model.sv
// core model: count pulse every machine cycle, one instruction per call
`timescale 1ns/100ps
`default_nettype none
module icw_core_model (input wire clock_i, output logic clk_o, svc_o, dis_o, exe_o);
	initial {clk_o, svc_o, dis_o, exe_o} = 4'h0;
	always @(posedge clock_i) clk_o <= 1'b1;
	task automatic run(input logic [2:0] v);
		@(posedge clock_i) {svc_o, dis_o, exe_o} <= v;
	endtask
endmodule // icw_core_model
`default_nettype wire

// ### tb/icw_watchdog_checker.sv
// watchdog port checker
`timescale 1ns/100ps
`default_nettype none
module icw_watchdog_checker (input wire clock_i, rstn_i, instr_clk_i, instr_exec_i,
	watchdog_service_instr_i, backup_entry_i, skip_next_o, watchdog_enable_flag_o,
	first_underflow_flag_o, second_underflow_flag_o, watchdog_reset_o, reset_pin_out_o,
	reset_pin_oe_n_o);
	wire svc = watchdog_service_instr_i && instr_exec_i;
	wire f1 = first_underflow_flag_o, en = watchdog_enable_flag_o;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	pin_a: assert property (!reset_pin_out_o) else $error("pin high");
	oe_a: assert property (reset_pin_oe_n_o || watchdog_reset_o) else $error("pin");
	skip_a: assert property (skip_next_o |-> $past(f1 && svc)) else $error("skip");
	en_a: assert property ($fell(en) |-> $past(svc)) else $error("en");
	bk_a: assert property (backup_entry_i |=> en && !f1) else $error("bk");
	f1_a: assert property ($rose(f1) |-> $past(instr_clk_i)) else $error("f1");
	wdr_a: assert property ($rose(watchdog_reset_o) |-> $past(f1 && en && instr_clk_i))
		else $error("wdr");
	f2_a: assert property (second_underflow_flag_o == watchdog_reset_o) else $error("f2");
	cover property (skip_next_o);
	cover property ($fell(en));
	cover property (backup_entry_i);
endmodule // icw_watchdog_checker
bind icw_watchdog icw_watchdog_checker icw_watchdog_checker_inst (.*);
`default_nettype wire

// ### tb/icw_watchdog_tb.sv
// bench for the instruction clock watchdog
`timescale 1ns/100ps
`default_nettype none
module icw_watchdog_tb;
	logic clock_i = 0, rstn_i = 0, backup_entry_i = 0;
	wire instr_clk_i, watchdog_service_instr_i, watchdog_disable_instr_i, instr_exec_i;
	wire skip_next_o, watchdog_enable_flag_o, first_underflow_flag_o, second_underflow_flag_o;
	wire watchdog_reset_o, reset_pin_out_o, reset_pin_oe_n_o;
	int failures = 0, samples_checked = 0;
	icw_watchdog icw_watchdog_inst (.*);
	icw_core_model icw_core_model_inst (.clock_i, .clk_o(instr_clk_i),
		.svc_o(watchdog_service_instr_i), .dis_o(watchdog_disable_instr_i), .exe_o(instr_exec_i));
	always #50 clock_i = ~clock_i;
	task chk(input logic got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %b", $time, got);
		end
	endtask
	task test_done;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// four instructions, {service, disable, execute} each, oldest first
	task play(input logic [11:0] q);
		for (int i = 9; i >= 0; i -= 3)
			icw_core_model_inst.run(q[i+:3]);
		#1;
	endtask
	task t_pairing;
		play(12'h668);
		chk(skip_next_o | ~watchdog_enable_flag_o, 0);
		play(12'h0e8);
		chk(watchdog_enable_flag_o, 0);
	endtask
	task t_underflow;
		repeat (70000) if (!first_underflow_flag_o) @(posedge clock_i) #1;
		chk($time > 6555000 && $time < 6556000, 1);
		play(12'h028);
		chk(skip_next_o & ~first_underflow_flag_o, 1);
		@(posedge clock_i) backup_entry_i <= 1'b1;
		@(posedge clock_i) backup_entry_i <= 1'b0;
		#1 chk(watchdog_enable_flag_o, 1);
		chk(watchdog_reset_o | second_underflow_flag_o | ~reset_pin_oe_n_o | reset_pin_out_o, 0);
	endtask
	initial
	begin
		repeat (16) @(posedge clock_i);
		rstn_i <= 1'b1;
		#1 chk(watchdog_enable_flag_o & reset_pin_oe_n_o & ~first_underflow_flag_o, 1);
		repeat (2) @(posedge clock_i);
		t_pairing;
		t_underflow;
		test_done;
	end
	initial
	begin
		#7000000;
		failures++;
		test_done;
	end
endmodule // icw_watchdog_tb
`default_nettype wire
